// ---- hdl/fecu_top.sv ----
// Purpose: control register, block sequencer and loader window of the correction unit
// Assumes: pins sampled synchronous to core_clk; normal_mode comes from the mode logic
// Notes: words are tapped as they leave the data buffer
// Functional notes
// - control register read/write, two bits read-only
// - bypass bit excludes data port words
// - presence bit inverts on every control register read in normal mode
// - enable low holds logic and syndromes reset
// - enable high accepts each new data word
// - read direction checks block plus syndrome bytes
// - write direction yields syndrome after 512 bytes
// - fault flag shows check result
// - boot block serves initial loader for execution
// - reset operating mode reads every register zero
`timescale 1ns/1ps
`include "fecu_defs.svh"
module fecu_top #(
  parameter int unsigned BLOCK_BYTES = `FECU_BLOCK_BYTES,
  parameter int unsigned SYN_BYTES = `FECU_SYN_BYTES,
  parameter int unsigned LDR_DEPTH = `FECU_LDR_BYTES,
  parameter int unsigned BUF_WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic normal_mode,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [12:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic fd_in_valid,
  input wire logic [BUF_WIDTH-1:0] fd_in_data,
  output logic fd_in_ready,
  output logic fd_out_valid,
  output logic [BUF_WIDTH-1:0] fd_out_data,
  input wire logic fd_out_ready,
  output logic [8*SYN_BYTES-1:0] syn_out,
  output logic syn_done
);
  localparam int unsigned LDR_AW = $clog2(LDR_DEPTH);
  localparam logic [7:0] CTL_RST = `FECU_CTL_RST;
  localparam logic [9:0] LAST_DATA = 10'(BLOCK_BYTES - 1);
  localparam logic [9:0] LAST_SYN = 10'(SYN_BYTES - 1);
  localparam fecu_pkg::fecu_core_t ST_RST = '{
    bypass: CTL_RST[`FECU_BIT_BYPASS],
    dir: CTL_RST[`FECU_BIT_DIR],
    en: CTL_RST[`FECU_BIT_EN],
    toggle: CTL_RST[`FECU_BIT_TOGGLE],
    err: CTL_RST[`FECU_BIT_ERR],
    phase: fecu_pkg::PH_OFF,
    cnt: 10'h000,
    ce_q: 1'b1,
    oe_q: 1'b1,
    we_q: 1'b1,
    rdata: 8'h00
  };

  fecu_pkg::fecu_core_t st_ff;
  fecu_pkg::fecu_core_t nxt_st;
  logic [7:0] ldr_mem [LDR_DEPTH];
  logic [7:0] lane_syn [SYN_BYTES];
  logic [7:0] view;
  logic ctl_hit;
  logic ldr_hit;
  logic rd_take;
  logic wr_take;
  logic tap;
  logic acc;
  logic lane_load;
  logic mismatch;

  // data buffer: a stalled flash side back-pressures the source
  fecu_buf2 #(
    .WIDTH(BUF_WIDTH)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(fd_in_valid),
    .in_data(fd_in_data),
    .in_ready(fd_in_ready),
    .out_valid(fd_out_valid),
    .out_data(fd_out_data),
    .out_ready(fd_out_ready)
  );

  // one accumulator per syndrome byte, each with its own power of x
  for (genvar g = 0; g < SYN_BYTES; g++) begin : g_lane
    fecu_syn_lane #(
      .SHIFTS(g + 1)
    ) u_lane (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .clear(!st_ff.en),
      .load(lane_load),
      .din(fd_out_data[7:0]),
      .syn(lane_syn[g])
    );
    assign syn_out[g*8 +: 8] = lane_syn[g];
  end

  // pin decode: reads start on oe falling, writes land on we rising
  assign ctl_hit = (addr == `FECU_CTL_OFS);
  assign ldr_hit = (addr < 13'(LDR_DEPTH));
  assign rd_take = !ce_n && !oe_n && st_ff.oe_q;
  assign wr_take = !st_ff.ce_q && we_n && !st_ff.we_q;
  assign dq_oe = !ce_n && !oe_n && (ctl_hit || ldr_hit);
  assign dq_out = st_ff.rdata;

  // reserved bits read their reset values, never the written data
  assign view = {st_ff.err, CTL_RST[6], st_ff.dir, CTL_RST[4], st_ff.en,
                 st_ff.toggle, CTL_RST[1], st_ff.bypass};

  // a word counts only when it leaves the buffer with the unit live
  assign tap = fd_out_valid && fd_out_ready;
  assign acc = tap && st_ff.en && !st_ff.bypass;
  assign lane_load = acc && (st_ff.phase == fecu_pkg::PH_DATA);
  assign mismatch = (fd_out_data[7:0] != lane_syn[st_ff.cnt[2:0]]);
  assign syn_done = (st_ff.phase == fecu_pkg::PH_DONE) && st_ff.dir;

  // loader bytes; writes program the window only in normal mode
  always_ff @(posedge core_clk) begin
    if (clk_en && wr_take && ldr_hit && normal_mode) begin
      ldr_mem[addr[LDR_AW-1:0]] <= dq_in;
    end
  end

  // sequencer and register file in one next-state pass
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ce_q = ce_n;
    nxt_st.oe_q = oe_n;
    nxt_st.we_q = we_n;
    // disabled unit parks its sequence and flag at reset values
    if (!st_ff.en) begin
      nxt_st.phase = fecu_pkg::PH_OFF;
      nxt_st.cnt = 10'h000;
      nxt_st.err = CTL_RST[`FECU_BIT_ERR];
    end else if (acc) begin
      case (st_ff.phase)
        fecu_pkg::PH_DATA: begin
          if (st_ff.cnt == LAST_DATA) begin
            nxt_st.cnt = 10'h000;
            // write direction stops here; read goes on to check bytes
            nxt_st.phase = st_ff.dir ? fecu_pkg::PH_DONE : fecu_pkg::PH_SYN;
          end else begin
            nxt_st.cnt = st_ff.cnt + 10'h001;
          end
        end
        fecu_pkg::PH_SYN: begin
          if (mismatch) begin
            nxt_st.err = 1'b1;
          end
          if (st_ff.cnt == LAST_SYN) begin
            nxt_st.phase = fecu_pkg::PH_DONE;
          end else begin
            nxt_st.cnt = st_ff.cnt + 10'h001;
          end
        end
        default: begin
          nxt_st.cnt = st_ff.cnt; // done: later words are ignored
        end
      endcase
    end
    // writable bits only; toggle is not touched, fault clears only when the write enables the unit
    if (wr_take && ctl_hit) begin
      nxt_st.bypass = dq_in[`FECU_BIT_BYPASS];
      nxt_st.dir = dq_in[`FECU_BIT_DIR];
      nxt_st.en = dq_in[`FECU_BIT_EN];
      if (dq_in[`FECU_BIT_EN] && !st_ff.en) begin
        nxt_st.phase = fecu_pkg::PH_DATA; // fresh block on enable
        nxt_st.cnt = 10'h000;
        nxt_st.err = 1'b0;
      end
    end
    // read data is captured at the start of the access
    if (rd_take) begin
      if (!normal_mode) begin
        nxt_st.rdata = 8'h00;
      end else if (ctl_hit) begin
        nxt_st.rdata = view;
        nxt_st.toggle = !st_ff.toggle;
      end else if (ldr_hit) begin
        nxt_st.rdata = ldr_mem[addr[LDR_AW-1:0]];
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
    // reset mode keeps the register at its reset value until normal
    if (!normal_mode) begin
      nxt_st.bypass = ST_RST.bypass;
      nxt_st.dir = ST_RST.dir;
      nxt_st.en = ST_RST.en;
      nxt_st.toggle = ST_RST.toggle;
      nxt_st.err = ST_RST.err;
      nxt_st.phase = fecu_pkg::PH_OFF;
      nxt_st.cnt = 10'h000;
    end
  end

  // reset ignores clk_en so the part always comes up defined
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge core_clk iff clk_en);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd_ctl;
    rd_take && ctl_hit && normal_mode;
  endsequence

  sequence s_last_write;
    acc && normal_mode && st_ff.dir && (st_ff.phase == fecu_pkg::PH_DATA) && (st_ff.cnt == LAST_DATA);
  endsequence

  ctl_reset_a: assert property (!$past(rst_n) |-> (view == 8'h82))
    else $error("control register not at reset value after reset");

  toggle_flip_a: assert property (s_rd_ctl |=> (st_ff.toggle != $past(st_ff.toggle)))
    else $error("presence bit did not invert on read");

  read_view_a: assert property (s_rd_ctl |=> (dq_out == $past(view)))
    else $error("register read returned wrong value");

  bypass_skip_a: assert property (tap && st_ff.bypass && st_ff.en && normal_mode && !wr_take
                                  |=> $stable(st_ff.cnt))
    else $error("bypassed word was counted");

  // an enabling write in the same cycle starts a fresh block instead
  disable_clear_a: assert property (!st_ff.en && !(wr_take && ctl_hit && normal_mode)
                                    |=> (st_ff.cnt == 10'h000) && (syn_out == '0)
                                    && (st_ff.phase == fecu_pkg::PH_OFF))
    else $error("disabled unit not held in reset");

  count_step_a: assert property (lane_load && normal_mode && (st_ff.cnt != LAST_DATA)
                                 |=> (st_ff.cnt == $past(st_ff.cnt) + 10'h001))
    else $error("accepted word not counted");

  check_flag_a: assert property (acc && normal_mode && (st_ff.phase == fecu_pkg::PH_SYN) && mismatch
                                 |=> st_ff.err [*2] or (st_ff.err ##1 !st_ff.en))
    else $error("syndrome mismatch did not raise fault");

  write_done_a: assert property (s_last_write |=> syn_done ##1 ($stable(syn_out) || !st_ff.en))
    else $error("syndrome not ready after full block");

  reset_mode_a: assert property (rd_take && !normal_mode |=> (dq_out == 8'h00))
    else $error("read in reset mode not zero");

  ro_ignore_a: assert property (wr_take && ctl_hit && normal_mode && st_ff.en && !acc && !rd_take
                                |=> $stable(st_ff.err) && $stable(st_ff.toggle))
    else $error("write changed a read-only bit");
endmodule

// ---- inc/fecu_defs.svh ----
// Purpose: shared constants of the flash correction unit
// Assumes: included by bare name after the package
// Notes: offsets are byte addresses inside the 8KB window
`ifndef FECU_DEFS_SVH
`define FECU_DEFS_SVH
`define FECU_CTL_OFS 13'h1046
`define FECU_CTL_RST 8'h82
`define FECU_BIT_BYPASS 0
`define FECU_BIT_TOGGLE 2
`define FECU_BIT_EN 3
`define FECU_BIT_DIR 5
`define FECU_BIT_ERR 7
`define FECU_BLOCK_BYTES 512
`define FECU_SYN_BYTES 6
`define FECU_SYN_RST 8'h00
`define FECU_GF_POLY 8'h1D
`define FECU_LDR_BYTES 1024
`endif

// ---- inc/fecu_pkg.sv ----
// Purpose: types of the flash correction unit
// Assumes: nothing
// Notes: all state except the loader memory travels as one packed struct per module
package fecu_pkg;
  typedef enum logic [3:0] {
    PH_OFF = 4'h1,
    PH_DATA = 4'h2,
    PH_SYN = 4'h4,
    PH_DONE = 4'h8
  } fecu_phase_t;

  typedef struct packed {
    logic bypass;
    logic dir;
    logic en;
    logic toggle;
    logic err;
    fecu_phase_t phase;
    logic [9:0] cnt;
    logic ce_q;
    logic oe_q;
    logic we_q;
    logic [7:0] rdata;
  } fecu_core_t;

  typedef struct packed {
    logic [7:0] acc;
  } fecu_lane_t;
endpackage

// ---- hdl/fecu_buf2.sv ----
// Purpose: two-entry buffer in the flash data path
// Assumes: inputs synchronous to core_clk
// Notes: head entry always sits in e0, so out_data is a flop
`timescale 1ns/1ps
module fecu_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [WIDTH-1:0] e0;
    logic [WIDTH-1:0] e1;
    logic [1:0] cnt;
  } fecu_buf_t;

  fecu_buf_t st_ff;
  fecu_buf_t nxt_st;
  logic push;
  logic pop;

  // handshakes straight from the fill level
  assign in_ready = (st_ff.cnt != 2'h2) && clk_en;
  assign out_valid = (st_ff.cnt != 2'h0);
  assign out_data = st_ff.e0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && clk_en;

  // shift-down queue: a pop always exposes the next word in e0
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.cnt)
      2'h0: begin
        if (push) begin
          nxt_st.e0 = in_data;
          nxt_st.cnt = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          nxt_st.e0 = in_data;
        end else if (push) begin
          nxt_st.e1 = in_data;
          nxt_st.cnt = 2'h2;
        end else if (pop) begin
          nxt_st.cnt = 2'h0;
        end
      end
      default: begin
        if (pop) begin
          nxt_st.e0 = st_ff.e1;
          nxt_st.cnt = 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ---- hdl/fecu_syn_lane.sv ----
// Purpose: one syndrome byte accumulator over GF(2^8)
// Assumes: clear has priority over load
// Notes: each lane multiplies by a different power of x
`timescale 1ns/1ps
`include "fecu_defs.svh"
module fecu_syn_lane #(
  parameter int unsigned SHIFTS = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic load,
  input wire logic [7:0] din,
  output logic [7:0] syn
);
  localparam logic [7:0] POLY = `FECU_GF_POLY;

  fecu_pkg::fecu_lane_t st_ff;
  fecu_pkg::fecu_lane_t nxt_st;

  // multiply by x^SHIFTS, reducing by the field polynomial each step
  function automatic logic [7:0] mulx(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    for (int i = 0; i < SHIFTS; i++) begin
      r = {r[6:0], 1'b0} ^ (r[7] ? POLY : 8'h00);
    end
    return r;
  endfunction

  assign syn = st_ff.acc;

  // clear wins so a disabled unit never accumulates
  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st.acc = `FECU_SYN_RST;
    end else if (load) begin
      nxt_st.acc = mulx(st_ff.acc) ^ din;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff.acc <= `FECU_SYN_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ---- tb/fecu_host_model.sv ----
// Purpose: host processor model on the register pins of the correction unit
// Assumes: pins change at the falling edge of core_clk
// Notes: released address and data lines carry inverted last values
`timescale 1ns/1ps
module fecu_host_model (
  input wire logic core_clk,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [12:0] addr,
  output logic [7:0] dq_in,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe
);
  // idle bus at time zero, strobes high
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 13'h0000;
    dq_in = 8'h00;
  end

  // write is taken where we_n rises, so data is held across that edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge core_clk);
    ce_n = 1'b0;
    we_n = 1'b0;
    addr = a;
    dq_in = d;
    @(negedge core_clk);
    we_n = 1'b1;
    @(negedge core_clk);
    ce_n = 1'b1;
    addr = ~a; // stale values must not look valid
    dq_in = ~d;
  endtask

  // read strobe held two edges so the answer has settled
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe);
    @(negedge core_clk);
    ce_n = 1'b0;
    addr = a;
    @(negedge core_clk);
    oe_n = 1'b0;
    #1 oe = dq_oe;
    repeat (2) @(negedge core_clk);
    d = dq_out;
    oe_n = 1'b1;
    ce_n = 1'b1;
    addr = ~a;
  endtask
endmodule

// ---- tb/tb_flash_ecc_control_unit.sv ----
// Purpose: self-checking bench of the correction unit control and data path
// Assumes: clk_en held high except during t_freeze; inputs change at the falling edge
// Notes: syndromes are rebuilt here lane by lane over GF(2^8)
`timescale 1ns/1ps
`include "fecu_defs.svh"
module tb_flash_ecc_control_unit;
  logic core_clk, rst_n, clk_en, normal_mode;
  logic ce_n, oe_n, we_n, dq_oe, syn_done;
  logic [12:0] addr;
  logic [7:0] dq_in, dq_out, fd_in_data, fd_out_data, d8;
  logic fd_in_valid, fd_in_ready, fd_out_valid, fd_out_ready, oe, tog;
  logic [47:0] syn_out, exp_syn;
  logic [7:0] q[$];
  int n_errors = 0;
  int comparisons = 0;

  fecu_top #(.BLOCK_BYTES(`FECU_BLOCK_BYTES), .SYN_BYTES(`FECU_SYN_BYTES), .LDR_DEPTH(`FECU_LDR_BYTES),
    .BUF_WIDTH(8)) dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .normal_mode(normal_mode),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .fd_in_valid(fd_in_valid), .fd_in_data(fd_in_data), .fd_in_ready(fd_in_ready),
    .fd_out_valid(fd_out_valid), .fd_out_data(fd_out_data), .fd_out_ready(fd_out_ready),
    .syn_out(syn_out), .syn_done(syn_done));

  fecu_host_model host (.core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // compare helpers, one per result width
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk48(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // control read; presence bit expected to alternate
  task automatic rdctl(input logic [7:0] base);
    host.rd(`FECU_CTL_OFS, d8, oe);
    chk8(d8, base | {5'h00, tog, 2'b00});
    tog = ~tog;
  endtask

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? `FECU_GF_POLY : 8'h00);
  endfunction

  // block pattern and its expected syndrome, lane g scales by x^(g+1)
  task automatic fill(input int k);
    logic [7:0] acc;
    q.delete();
    for (int i = 0; i < `FECU_BLOCK_BYTES; i++) q.push_back(8'(i * k + 3));
    for (int g = 0; g < `FECU_SYN_BYTES; g++) begin
      acc = 8'h00;
      for (int i = 0; i < `FECU_BLOCK_BYTES; i++) begin
        for (int s = 0; s <= g; s++) acc = xt(acc);
        acc = acc ^ q[i];
      end
      exp_syn[8*g +: 8] = acc;
    end
  endtask

  // push q through the buffer; sink stalls first so the buffer must fill
  task automatic stream();
    int i, o, cyc;
    logic full;
    i = 0;
    o = 0;
    cyc = 0;
    full = 1'b0;
    while (o < q.size() && cyc < 4000) begin
      @(negedge core_clk);
      fd_in_valid = (i < q.size());
      fd_in_data = fd_in_valid ? q[i] : ~fd_in_data;
      fd_out_ready = (cyc >= 4) && (cyc % 3 != 0);
      #1;
      if (!fd_in_ready) full = 1'b1;
      if (fd_in_valid && fd_in_ready) i++;
      if (fd_out_valid && fd_out_ready) begin
        chk8(fd_out_data, q[o]);
        o++;
      end
      cyc++;
    end
    @(negedge core_clk);
    fd_in_valid = 1'b0;
    fd_out_ready = 1'b0;
    chk8({7'h00, full}, 8'h01);
    chk8(8'(q.size() - o), 8'h00);
    repeat (3) @(negedge core_clk);
  endtask

  task automatic t_reset_mode();
    host.rd(`FECU_CTL_OFS, d8, oe);
    chk8(d8, 8'h00);
    normal_mode = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic t_reset_value();
    rdctl(8'h82);
    rdctl(8'h82);
  endtask

  task automatic t_readonly();
    host.wr(`FECU_CTL_OFS, 8'hD7);
    rdctl(8'h83);
  endtask

  // clock enable low: a whole write cycle on the pins must be lost
  task automatic t_freeze();
    @(negedge core_clk);
    clk_en = 1'b0;
    host.wr(`FECU_CTL_OFS, 8'h08);
    chk8({7'h00, fd_in_ready}, 8'h00);
    clk_en = 1'b1;
    rdctl(8'h83);
  endtask

  task automatic t_write_block();
    host.wr(`FECU_CTL_OFS, 8'h28);
    rdctl(8'h2A);
    fill(5);
    stream();
    chk8({7'h00, syn_done}, 8'h01);
    chk48(syn_out, exp_syn);
  endtask

  task automatic t_disable();
    host.wr(`FECU_CTL_OFS, 8'h00);
    repeat (2) @(negedge core_clk);
    chk48(syn_out, 48'h0);
    chk8({7'h00, syn_done}, 8'h00);
    rdctl(8'h82);
  endtask

  // read direction: block then its check bytes, one corrupted if bad
  task automatic t_read_check(input logic bad);
    host.wr(`FECU_CTL_OFS, 8'h00);
    host.wr(`FECU_CTL_OFS, 8'h08);
    fill(9);
    for (int g = 0; g < `FECU_SYN_BYTES; g++) q.push_back(exp_syn[8*g +: 8] ^ {7'h00, bad && g == 0});
    stream();
    rdctl(bad ? 8'h8A : 8'h0A);
  endtask

  task automatic t_bypass();
    host.wr(`FECU_CTL_OFS, 8'h00);
    host.wr(`FECU_CTL_OFS, 8'h29);
    fill(3);
    stream();
    chk8({7'h00, syn_done}, 8'h00);
    chk48(syn_out, 48'h0);
  endtask

  task automatic t_loader();
    host.wr(13'h0010, 8'h5A);
    host.rd(13'h0010, d8, oe);
    chk8(d8, 8'h5A);
    chk8({7'h00, oe}, 8'h01);
    host.rd(13'h1FFF, d8, oe);
    chk8(d8, 8'h00);
    chk8({7'h00, oe}, 8'h00);
  endtask

  task automatic final_report();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    normal_mode = 1'b0;
    fd_in_valid = 1'b0;
    fd_in_data = 8'h00;
    fd_out_ready = 1'b0;
    tog = 1'b0;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset_mode();
    t_reset_value();
    t_readonly();
    t_freeze();
    t_write_block();
    t_disable();
    t_read_check(1'b0);
    t_read_check(1'b1);
    t_bypass();
    t_loader();
    final_report();
  end

  // watchdog, well beyond the expected few thousand cycles
  initial begin
    #400000;
    n_errors++;
    $display("unexpected at %0t: watchdog %h %h", $time, 1'b1, 1'b0);
    final_report();
  end
endmodule
